/* File: include/smb_pkg.sv */
package smb_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned BOOT_WIN_MS  = 1000;
  localparam int unsigned MC_WIN_MS    = 10000;
  localparam int unsigned BOOT_WIN_CYC = (CLK_HZ / 1000) * BOOT_WIN_MS;
  localparam int unsigned MC_WIN_CYC   = (CLK_HZ / 1000) * MC_WIN_MS;

  // ****************************************************************
  // Characters and reply bytes
  // ****************************************************************
  localparam logic [7:0]  CH_HASH   = 8'h23;
  localparam logic [7:0]  CH_X      = 8'h78;
  localparam logic [7:0]  CH_CR     = 8'h0D;
  localparam logic [7:0]  CH_LF     = 8'h0A;
  localparam logic [7:0]  ACK_OK    = 8'h11;
  localparam logic [7:0]  ACK_CRC   = 8'h22;
  localparam logic [2:0]  MC_KEYS   = 3'h5;
  localparam logic [63:0] BOOT_STR  = 64'h626F6F7400000000;
  localparam logic [15:0] CRC_INIT  = 16'hFFFF;
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [15:0] MCCNT_RST = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_HASH = 3'h0,
    ST_WAIT = 3'h1,
    ST_BVER = 3'h3,
    ST_LENH = 3'h2,
    ST_LENL = 3'h6,
    ST_DATA = 3'h7,
    ST_ACK  = 3'h5,
    ST_APP  = 3'h4
  } smb_state_t;

  typedef struct packed {
    logic [31:0] hw_type;
    logic [31:0] serial;
    logic [63:0] fw_ver;
    logic        boot;
  } smb_ver_fields_t;

  // CRC-16 step, MSB first; a frame with its CRC appended leaves zero.
  function automatic logic [15:0] smb_crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

endpackage

/* File: design/smb_core.sv */
`timescale 1ns/1ns
// Overview of operation
// - Version sentence is sent once when the application starts after power-up.
// - A version request makes the block send the version sentence.
// - In bootloader mode the firmware field reads boot.
// - Master clear pulses erase and increments the preserved master clear counter.
// - Five x then CR or LF within 10 s of startup fires master clear.
// - After reset send hash; a hash echoed within 1 s enters bootloader.
// - Entering bootloader sends the version sentence marked boot.
// - Each frame is answered with 0x11 if good, 0x22 on CRC error.
// - After the final frame succeeds the block restarts into new firmware.
// - Each frame starts with a two-byte big-endian length of the bytes after it, CRC included.
// - A zero-length frame holds no data and is answered at once.
// - A time and date request makes the block send that sentence.

module smb_core #(
  parameter int unsigned BOOT_WIN_CYC = smb_pkg::BOOT_WIN_CYC,
  parameter int unsigned MC_WIN_CYC   = smb_pkg::MC_WIN_CYC
) (
  // Clock, reset, enable
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     en_i,
  // Startup and requests from the sentence parser
  input  wire logic                     restart_req_i,
  input  wire logic                     ver_req_i,
  input  wire logic                     td_req_i,
  input  wire logic                     last_frame_i,
  // Received byte stream
  input  wire logic [7:0]               rx_data_i,
  input  wire logic                     rx_valid_i,
  // Transmit byte stream
  output logic      [7:0]               tx_data_o,
  output logic                          tx_valid_o,
  input  wire logic                     tx_ready_i,
  // Version fields and sentence triggers
  input  wire logic [31:0]              hw_type_i,
  input  wire logic [31:0]              serial_i,
  input  wire logic [63:0]              fw_ver_i,
  output logic                          ver_send_o,
  output smb_pkg::smb_ver_fields_t      ver_fields_o,
  output logic                          td_send_o,
  // Master clear
  output logic                          mc_clear_o,
  output logic      [15:0]              mc_count_o,
  // Firmware transfer
  output logic                          boot_mode_o,
  output logic      [7:0]               fw_byte_o,
  output logic                          fw_valid_o,
  output logic                          frame_ok_o,
  output logic                          frame_bad_o,
  output logic                          restart_o
);

  if (BOOT_WIN_CYC == 0 || MC_WIN_CYC < BOOT_WIN_CYC) begin : g_bad_windows
    $error("smb_core: startup windows must be nonzero and ordered");
  end

  // ****************************************************************
  // Startup, bootloader and frame receiver
  // ****************************************************************
  smb_pkg::smb_state_t      st_reg,      st_next;
  logic [31:0]              tmr_reg,     tmr_next;
  logic [15:0]              len_reg,     len_next;
  logic [15:0]              crc_reg,     crc_next;
  logic [7:0]               tx_reg,      tx_next;
  logic [7:0]               fwb_reg,     fwb_next;
  logic                     boot_reg,    boot_next;
  logic                     good_reg,    good_next;
  logic                     vsend_reg,   vsend_next;
  logic                     tsend_reg,   tsend_next;
  logic                     fwv_reg,     fwv_next;
  logic                     fok_reg,     fok_next;
  logic                     fbad_reg,    fbad_next;
  logic                     rst_reg,     rst_next;
  smb_pkg::smb_ver_fields_t vf_reg,      vf_next;
  logic [15:0]              crc_in;
  logic                     restart_any;

  assign crc_in      = smb_pkg::smb_crc_step(crc_reg, rx_data_i);
  assign restart_any = restart_req_i || rst_next;

  always_comb begin
    st_next    = st_reg;
    tmr_next   = (tmr_reg < MC_WIN_CYC) ? tmr_reg + 32'h1 : tmr_reg;
    len_next   = len_reg;
    crc_next   = crc_reg;
    tx_next    = tx_reg;
    fwb_next   = fwb_reg;
    boot_next  = boot_reg;
    good_next  = good_reg;
    vsend_next = ver_req_i;
    tsend_next = td_req_i;
    fwv_next   = 1'b0;
    fok_next   = 1'b0;
    fbad_next  = 1'b0;
    rst_next   = 1'b0;
    case (st_reg)
      smb_pkg::ST_HASH: begin
        if (tx_ready_i) begin
          st_next = smb_pkg::ST_WAIT;
        end
      end
      smb_pkg::ST_WAIT: begin
        if (rx_valid_i && rx_data_i == smb_pkg::CH_HASH && tmr_reg < BOOT_WIN_CYC) begin
          st_next = smb_pkg::ST_BVER;
        end else if (tmr_reg >= BOOT_WIN_CYC) begin
          st_next    = smb_pkg::ST_APP;
          vsend_next = 1'b1;
        end
      end
      smb_pkg::ST_APP: begin
        st_next = smb_pkg::ST_APP;
      end
      smb_pkg::ST_BVER: begin
        boot_next  = 1'b1;
        vsend_next = 1'b1;
        st_next    = smb_pkg::ST_LENH;
      end
      smb_pkg::ST_LENH: begin
        if (rx_valid_i) begin
          len_next[15:8] = rx_data_i;
          crc_next       = smb_pkg::smb_crc_step(smb_pkg::CRC_INIT, rx_data_i);
          st_next        = smb_pkg::ST_LENL;
        end
      end
      smb_pkg::ST_LENL: begin
        if (rx_valid_i) begin
          len_next[7:0] = rx_data_i;
          crc_next      = crc_in;
          if ({len_reg[15:8], rx_data_i} == 16'h0000) begin
            tx_next   = smb_pkg::ACK_OK;
            good_next = 1'b1;
            fok_next  = 1'b1;
            st_next   = smb_pkg::ST_ACK;
          end else begin
            st_next = smb_pkg::ST_DATA;
          end
        end
      end
      smb_pkg::ST_DATA: begin
        if (rx_valid_i) begin
          fwb_next = rx_data_i;
          fwv_next = 1'b1;
          crc_next = crc_in;
          len_next = len_reg - 16'h1;
          if (len_reg == 16'h1) begin
            good_next = (crc_in == 16'h0000);
            tx_next   = (crc_in == 16'h0000) ? smb_pkg::ACK_OK : smb_pkg::ACK_CRC;
            fok_next  = (crc_in == 16'h0000);
            fbad_next = (crc_in != 16'h0000);
            st_next   = smb_pkg::ST_ACK;
          end
        end
      end
      smb_pkg::ST_ACK: begin
        if (tx_ready_i) begin
          if (good_reg && last_frame_i) begin
            rst_next = 1'b1;
          end else begin
            st_next = smb_pkg::ST_LENH;
          end
        end
      end
      default: begin
        st_next = smb_pkg::ST_HASH;
      end
    endcase
    // Either restart source reruns the whole startup, including the hash offer.
    if (restart_req_i || rst_next) begin
      st_next   = smb_pkg::ST_HASH;
      tmr_next  = 32'h0;
      boot_next = 1'b0;
      tx_next   = smb_pkg::CH_HASH;
    end
    vf_next = vf_reg;
    if (vsend_next) begin
      vf_next.hw_type = hw_type_i;
      vf_next.serial  = serial_i;
      vf_next.fw_ver  = boot_next ? smb_pkg::BOOT_STR : fw_ver_i;
      vf_next.boot    = boot_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg    <= smb_pkg::ST_HASH;
      tmr_reg   <= 32'h0;
      len_reg   <= 16'h0;
      crc_reg   <= smb_pkg::CRC_INIT;
      tx_reg    <= smb_pkg::CH_HASH;
      fwb_reg   <= 8'h0;
      boot_reg  <= 1'b0;
      good_reg  <= 1'b0;
      vsend_reg <= 1'b0;
      tsend_reg <= 1'b0;
      fwv_reg   <= 1'b0;
      fok_reg   <= 1'b0;
      fbad_reg  <= 1'b0;
      rst_reg   <= 1'b0;
      vf_reg    <= '0;
    end else if (en_i) begin
      st_reg    <= st_next;
      tmr_reg   <= tmr_next;
      len_reg   <= len_next;
      crc_reg   <= crc_next;
      tx_reg    <= tx_next;
      fwb_reg   <= fwb_next;
      boot_reg  <= boot_next;
      good_reg  <= good_next;
      vsend_reg <= vsend_next;
      tsend_reg <= tsend_next;
      fwv_reg   <= fwv_next;
      fok_reg   <= fok_next;
      fbad_reg  <= fbad_next;
      rst_reg   <= rst_next;
      vf_reg    <= vf_next;
    end
  end

  // ****************************************************************
  // Master clear key recogniser
  // ****************************************************************
  logic [2:0]  mck_reg,  mck_next;
  logic        mcl_reg,  mcl_next;
  logic        mcp_reg,  mcp_next;
  logic [15:0] mcc_reg,  mcc_next;

  always_comb begin
    mck_next = mck_reg;
    mcl_next = mcl_reg;
    mcp_next = 1'b0;
    mcc_next = mcc_reg;
    if (tmr_reg >= MC_WIN_CYC) begin
      mcl_next = 1'b0;
    end else if (mcl_reg && rx_valid_i) begin
      if (rx_data_i == smb_pkg::CH_X && mck_reg < smb_pkg::MC_KEYS) begin
        mck_next = mck_reg + 3'h1;
      end else if (mck_reg == smb_pkg::MC_KEYS &&
                   (rx_data_i == smb_pkg::CH_CR || rx_data_i == smb_pkg::CH_LF)) begin
        mcp_next = 1'b1;
        mcc_next = mcc_reg + 16'h1;
        mcl_next = 1'b0;
      end else begin
        mcl_next = 1'b0;
      end
    end
    // A new startup rearms recognition; the counter is kept across it.
    if (restart_any) begin
      mck_next = 3'h0;
      mcl_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mck_reg <= 3'h0;
      mcl_reg <= 1'b1;
      mcp_reg <= 1'b0;
      mcc_reg <= smb_pkg::MCCNT_RST;
    end else if (en_i) begin
      mck_reg <= mck_next;
      mcl_reg <= mcl_next;
      mcp_reg <= mcp_next;
      mcc_reg <= mcc_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign tx_valid_o   = (st_reg == smb_pkg::ST_HASH) || (st_reg == smb_pkg::ST_ACK);
  assign tx_data_o    = tx_reg;
  assign ver_send_o   = vsend_reg;
  assign ver_fields_o = vf_reg;
  assign td_send_o    = tsend_reg;
  assign mc_clear_o   = mcp_reg;
  assign mc_count_o   = mcc_reg;
  assign boot_mode_o  = boot_reg;
  assign fw_byte_o    = fwb_reg;
  assign fw_valid_o   = fwv_reg;
  assign frame_ok_o   = fok_reg;
  assign frame_bad_o  = fbad_reg;
  assign restart_o    = rst_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  hash_offer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_reg == smb_pkg::ST_HASH) |-> (tx_valid_o && tx_data_o == smb_pkg::CH_HASH))
    else $error("hash not offered after startup");

  boot_entry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && !restart_req_i && st_reg == smb_pkg::ST_WAIT && rx_valid_i &&
     rx_data_i == smb_pkg::CH_HASH && tmr_reg < BOOT_WIN_CYC) |=> (st_reg == smb_pkg::ST_BVER))
    else $error("echoed hash did not enter bootloader");

  boot_version_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && !restart_req_i && st_reg == smb_pkg::ST_BVER) |=>
      (ver_send_o && ver_fields_o.boot && ver_fields_o.fw_ver == smb_pkg::BOOT_STR && boot_mode_o))
    else $error("bootloader entry sent no boot version");

  ack_value_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && !restart_req_i && st_reg == smb_pkg::ST_DATA && rx_valid_i && len_reg == 16'h1) |=>
      (st_reg == smb_pkg::ST_ACK && tx_valid_o &&
       tx_data_o == ($past(crc_in) == 16'h0000 ? smb_pkg::ACK_OK : smb_pkg::ACK_CRC)))
    else $error("wrong frame reply byte");

  empty_frame_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && !restart_req_i && st_reg == smb_pkg::ST_LENL && rx_valid_i &&
     len_reg[15:8] == 8'h00 && rx_data_i == 8'h00) |=> (tx_data_o == smb_pkg::ACK_OK && frame_ok_o))
    else $error("empty frame not acknowledged");

  final_restart_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && st_reg == smb_pkg::ST_ACK && tx_ready_i && good_reg && last_frame_i) |=>
      (restart_o && st_reg == smb_pkg::ST_HASH && !boot_mode_o))
    else $error("no restart after final frame");

  mc_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(mc_clear_o) |-> (mc_count_o == $past(mc_count_o) + 16'h1))
    else $error("master clear counter not incremented");

  mc_window_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(mc_clear_o) |-> ($past(tmr_reg) < MC_WIN_CYC && $past(mck_reg) == smb_pkg::MC_KEYS))
    else $error("master clear outside window or short key");

  mc_abandon_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && !restart_req_i && mcl_reg && rx_valid_i && rx_data_i != smb_pkg::CH_X &&
     rx_data_i != smb_pkg::CH_CR && rx_data_i != smb_pkg::CH_LF) |=> (!mcl_reg && !mc_clear_o))
    else $error("stray character did not abandon master clear");

  ver_request_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && ver_req_i) |=> ver_send_o)
    else $error("version request not answered");

  td_request_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && td_req_i) |=> td_send_o)
    else $error("time and date request not forwarded");

endmodule // smb_core

/* File: dv/smb_host_model.sv */
`timescale 1ns/1ns
// ********************************************************
// Upgrading host: sends bytes and frames, collects replies.
// ********************************************************
module smb_host_model (
  // Clock
  input  wire logic       clk_i,
  // Byte streams
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o
);
  logic timed_out;

  initial begin
    rx_data_o  = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
    timed_out  = 1'b0;
  end

  // Idle data shows the inverse of the last byte, so a stale byte never passes for a fresh one.
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk_i);
    rx_data_o  <= b;
    rx_valid_o <= 1'b1;
    @(negedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~b;
  endtask

  task automatic get_tx(output logic [7:0] b);
    int n;
    b = 8'h00;
    n = 0;
    @(negedge clk_i);
    while (tx_valid_i !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 300) begin
      timed_out = 1'b1;
    end else begin
      b = tx_data_i;
      tx_ready_o <= 1'b1;
      @(negedge clk_i);
      tx_ready_o <= 1'b0;
    end
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {q[i], 8'h00};
      for (int k = 0; k < 8; k++) begin
        c = c[15] ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Payload arrives already decoded from hex pairs; bad flips one check bit.
  task automatic send_frame(input logic [7:0] pl[$], input logic bad, output logic [7:0] ack);
    logic [7:0]  q[$];
    logic [15:0] c;
    q = pl;
    if (pl.size() > 0) begin
      q.push_front(8'(pl.size() + 2));
      q.push_front(8'((pl.size() + 2) >> 8));
      c = crc16(q) ^ {15'h0000, bad};
      q.push_back(c[15:8]);
      q.push_back(c[7:0]);
    end else begin
      q = '{8'h00, 8'h00};
    end
    foreach (q[i]) send_byte(q[i]);
    get_tx(ack);
  endtask
endmodule // smb_host_model

/* File: dv/tb_serial_maintenance_bootloader.sv */
`timescale 1ns/1ns
// ********************************************************
// Bench: startup, requests, master clear, firmware load.
// ********************************************************
module tb_serial_maintenance_bootloader;
  localparam int unsigned BOOT_CYC = 50;
  localparam int unsigned MC_CYC   = 200;
  localparam logic [31:0] HW_TYPE  = 32'h54535431; // Arbitrary value.
  localparam logic [31:0] SERIAL   = 32'h0000ABCD; // Arbitrary value.
  localparam logic [63:0] FW_VER   = 64'h312E302E30000000;

  logic                     clk_i, rst_n_i, restart_req_i, ver_req_i, td_req_i, last_frame_i, en_i;
  logic [7:0]               fw_q[$];
  logic                     rx_valid_i, tx_valid_o, tx_ready_i, ver_send_o, td_send_o, mc_clear_o;
  logic                     boot_mode_o, fw_valid_o, frame_ok_o, frame_bad_o, restart_o;
  logic [7:0]               rx_data_i, tx_data_o, fw_byte_o, b;
  logic [15:0]              mc_count_o;
  logic [7:0]               none_q[$];
  smb_pkg::smb_ver_fields_t ver_fields_o, last_fields;
  int                       n_fail, n_checks, n_ver, n_td, n_mc, n_fw, n_ok, n_bad, n_rst, v, f;

  smb_core #(.BOOT_WIN_CYC(BOOT_CYC), .MC_WIN_CYC(MC_CYC)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .restart_req_i(restart_req_i),
    .ver_req_i(ver_req_i), .td_req_i(td_req_i), .last_frame_i(last_frame_i),
    .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .hw_type_i(HW_TYPE), .serial_i(SERIAL), .fw_ver_i(FW_VER),
    .ver_send_o(ver_send_o), .ver_fields_o(ver_fields_o), .td_send_o(td_send_o),
    .mc_clear_o(mc_clear_o), .mc_count_o(mc_count_o), .boot_mode_o(boot_mode_o),
    .fw_byte_o(fw_byte_o), .fw_valid_o(fw_valid_o), .frame_ok_o(frame_ok_o),
    .frame_bad_o(frame_bad_o), .restart_o(restart_o));

  smb_host_model host (.clk_i(clk_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
    .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (ver_send_o === 1'b1) last_fields = ver_fields_o;
    n_ver = n_ver + int'(ver_send_o === 1'b1);
    n_td  = n_td + int'(td_send_o === 1'b1);
    n_mc  = n_mc + int'(mc_clear_o === 1'b1);
    n_fw  = n_fw + int'(fw_valid_o === 1'b1);
    if (fw_valid_o === 1'b1) fw_q.push_back(fw_byte_o);
    n_ok  = n_ok + int'(frame_ok_o === 1'b1);
    n_bad = n_bad + int'(frame_bad_o === 1'b1);
    n_rst = n_rst + int'(restart_o === 1'b1);
  end

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
    @(negedge clk_i);
  endtask

  // Bounded wait on an event counter; running out ends the run.
  task automatic wait_for(ref int c, input int tgt);
    int n;
    n = 0;
    while (c < tgt && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    if (c < tgt) begin
      n_fail++;
      $display("[FAIL] %0t wait ran out", $time);
      wrap_up();
    end
  endtask

  task automatic keys(input int nx, input logic [7:0] mid, input logic [7:0] term);
    for (int i = 0; i < nx; i++) host.send_byte(8'h78);
    if (mid !== 8'h00) host.send_byte(mid);
    for (int i = 0; i < 5; i++) host.send_byte(8'h78);
    host.send_byte(term);
    repeat (2) @(negedge clk_i);
  endtask

  task automatic t_powerup();
    chk(tx_valid_o === 1'b1 && tx_data_o === 8'h23, "no hash after reset");
    host.get_tx(b);
    wait_for(n_ver, 1);
    chk(last_fields === {HW_TYPE, SERIAL, FW_VER, 1'b0}, "power-up version fields");
    repeat (30) @(negedge clk_i);
    chk(n_ver == 1 && boot_mode_o === 1'b0, "version sent more than once");
  endtask

  task automatic t_requests();
    v = n_ver;
    f = n_td;
    pulse(ver_req_i);
    chk(n_ver == v + 1, "version request unanswered");
    pulse(td_req_i);
    chk(n_td == f + 1 && n_ver == v + 1, "time request unanswered");
    // With the enable low every flop holds, so a request in that time is lost.
    en_i = 1'b0;
    pulse(ver_req_i);
    chk(n_ver == v + 1 && ver_send_o === 1'b0, "request taken while disabled");
    en_i = 1'b1;
  endtask

  task automatic t_mclear();
    pulse(restart_req_i);
    keys(0, 8'h00, 8'h0D);
    chk(n_mc == 1 && mc_count_o === 16'h0001, "master clear missing");
    pulse(restart_req_i);
    keys(4, 8'h61, 8'h0A);
    chk(n_mc == 1 && mc_count_o === 16'h0001, "clear after stray byte");
    pulse(restart_req_i);
    repeat (MC_CYC + 10) @(negedge clk_i);
    keys(0, 8'h00, 8'h0A);
    chk(n_mc == 1 && mc_count_o === 16'h0001, "clear after window");
    pulse(restart_req_i);
    keys(0, 8'h00, 8'h0A);
    chk(n_mc == 2 && mc_count_o === 16'h0002, "counter not incremented");
  endtask

  // Image frames start after the three header frames, which the host never sends.
  task automatic t_boot();
    pulse(restart_req_i);
    host.get_tx(b);
    chk(b === 8'h23, "hash not sent after restart");
    v = n_ver;
    host.send_byte(8'h23);
    wait_for(n_ver, v + 1);
    chk(last_fields.boot === 1'b1 && last_fields.fw_ver === 64'h626F6F7400000000, "no boot version");
    chk(boot_mode_o === 1'b1, "bootloader not entered");
    host.send_frame(none_q, 1'b0, b);
    chk(b === 8'h11, "empty frame reply");
    v = n_ok;
    f = n_fw;
    fw_q.delete();
    host.send_frame('{8'h5A, 8'h3C}, 1'b0, b);
    chk(b === 8'h11 && n_ok == v + 1 && n_fw == f + 4, "good frame reply");
    chk(fw_q.size() == 4 && fw_q[0] === 8'h5A && fw_q[1] === 8'h3C, "data bytes not passed on");
    v = n_bad;
    host.send_frame('{8'h69, 8'h96, 8'h00}, 1'b1, b);
    chk(b === 8'h22 && n_bad == v + 1, "bad frame reply");
    host.send_frame('{8'h69, 8'h96, 8'h00}, 1'b0, b);
    chk(b === 8'h11, "retransmitted frame reply");
    last_frame_i = 1'b1;
    v = n_rst;
    host.send_frame('{8'hA5}, 1'b0, b);
    wait_for(n_rst, v + 1);
    last_frame_i = 1'b0;
    chk(b === 8'h11 && boot_mode_o === 1'b0 && tx_data_o === 8'h23, "no restart after last frame");
  endtask

  task automatic wrap_up();
    if (host.timed_out === 1'b1) n_fail++;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    {rst_n_i, restart_req_i, ver_req_i, td_req_i, last_frame_i} = 5'h00;
    en_i = 1'b1;
    {n_fail, n_checks, n_ver, n_td, n_mc, n_fw, n_ok, n_bad, n_rst} = '0;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_powerup();
    t_requests();
    t_mclear();
    t_boot();
    wrap_up();
  end
endmodule // tb_serial_maintenance_bootloader
